// >>> verilog/crab_pkg.sv
package crab_pkg;
  // Widths of the register path
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Controller clock figure, in kHz
  localparam int CAN_CLK_KHZ = 8000;
  // Processor clock figure, in kHz
  localparam int CPU_CLK_KHZ = 10000;
  // Access gap in processor cycles, ratio rounded up
  localparam int GAP_RAW = (CPU_CLK_KHZ + CAN_CLK_KHZ - 1) / CAN_CLK_KHZ;
  // Least gap between the two halves of a read
  localparam int READ_MIN_GAP = 2;
  localparam logic [3:0] WR_GAP = 4'(GAP_RAW);
  localparam logic [3:0] RD_GAP =
    4'((GAP_RAW > READ_MIN_GAP) ? GAP_RAW : READ_MIN_GAP);
  // Wait for the retrieving read to land: one gap of
  // controller edges plus the read data register
  localparam logic [3:0] FETCH_WAIT = 4'(GAP_RAW + 1);
  // Value after reset of the data path
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] CNT_RST = 4'h0;
  // Master sequencer states, one-hot
  typedef enum logic [3:0] {
    CRAB_IDLE = 4'b0001,
    CRAB_WAIT = 4'b0010,
    CRAB_GAP = 4'b0100,
    CRAB_FETCH = 4'b1000
  } crab_state_t;
endpackage

// >>> verilog/crab_if.sv
`timescale 1ns/1ps
// Register path between master and controller ends
interface crab_if;
  logic req; // Access strobe, one cycle
  logic wr; // High for a write
  logic [crab_pkg::ADDR_W-1:0] addr; // Register word address
  logic [crab_pkg::DATA_W-1:0] wdata; // Write data
  logic [crab_pkg::DATA_W-1:0] rdata; // Read data, registered
  modport master (output req, output wr, output addr, output wdata,
    input rdata);
  modport ctrl (input req, input wr, input addr, input wdata,
    output rdata);
endinterface

// >>> verilog/crab_ctrl.sv
`timescale 1ns/1ps
module crab_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  crab_if.ctrl bus,
  // Controller-side register file port
  output logic o_reg_we,
  output logic [crab_pkg::ADDR_W-1:0] o_reg_addr,
  output logic [crab_pkg::DATA_W-1:0] o_reg_wdata,
  input wire logic [crab_pkg::DATA_W-1:0] i_reg_rdata,
  // Toggles once per controller-clock edge
  input wire logic i_can_tick
);
  // ************************************************
  // Domain crossing
  // ************************************************
  // The tick arrives as a toggle, not a pulse. A pulse of
  // the slower domain could fall between two core samples;
  // each toggle level outlasts one core cycle, so no edge
  // is lost while the core clock stays the faster one.
  // A core clock slower than the controller would need a
  // different scheme; two edges could then fall between samples and be lost.
  logic tick_s1_reg; // First stage, read only by second
  logic tick_s2_reg; // Second stage, first settled copy
  logic tick_s3_reg; // History for change detection
  logic can_edge; // High one cycle per controller edge

  // First synchroniser stage; may go metastable
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Known level out of reset
      tick_s1_reg <= 1'b0;
    end else if (i_ce) begin
      // Raw sample of the foreign level
      tick_s1_reg <= i_can_tick;
    end
  end

  // Second synchroniser stage
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Cleared with the first stage
      tick_s2_reg <= 1'b0;
    end else if (i_ce) begin
      // Only this stage reads the first one
      tick_s2_reg <= tick_s1_reg;
    end
  end

  // One cycle of history of the settled level
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Same level as the chain, so no edge in reset
      tick_s3_reg <= 1'b0;
    end else if (i_ce) begin
      // Follows the second stage
      tick_s3_reg <= tick_s2_reg;
    end
  end

  // Either direction of the settled toggle is one edge.
  // Out of reset a high tick gives one spare event; it is
  // harmless, as nothing is pending then.
  assign can_edge = tick_s2_reg ^ tick_s3_reg;

  // ************************************************
  // Request capture
  // ************************************************
  // Only one access can wait for the controller edge. A new
  // request simply overwrites a waiting one; this is the
  // corruption a too-close access suffers.
  logic pend_reg; // An access waits for its edge
  logic pend_wr_reg; // The waiting access is a write
  logic [crab_pkg::ADDR_W-1:0] pend_addr_reg; // Its word address
  logic [crab_pkg::DATA_W-1:0] pend_wdata_reg; // Its write data
  logic apply; // Controller edge takes the access
  logic apply_wr; // Applied access writes
  logic apply_rd; // Applied access reads

  // A controller edge that meets a fresh strobe is given
  // up: the fresh access wins and the old one is lost.
  assign apply = can_edge & pend_reg & ~bus.req;
  assign apply_wr = apply & pend_wr_reg;
  assign apply_rd = apply & ~pend_wr_reg;

  // Waiting flag; a strobe and an apply never meet
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Nothing waits after reset
      pend_reg <= 1'b0;
    end else if (i_ce) begin
      if (bus.req) begin
        // New access takes the slot
        pend_reg <= 1'b1;
      end else if (apply) begin
        // Handed to the controller side
        pend_reg <= 1'b0;
      end
    end
  end

  // Kind and address of the waiting access
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Cleared fields
      pend_wr_reg <= 1'b0;
      pend_addr_reg <= '0;
    end else if (i_ce) begin
      if (bus.req) begin
        // Overwrite whatever still waits.
        pend_wr_reg <= bus.wr;
        pend_addr_reg <= bus.addr;
      end
    end
  end

  // Write data of the waiting access
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Cleared data
      pend_wdata_reg <= crab_pkg::DATA_RST;
    end else if (i_ce) begin
      if (bus.req) begin
        // Taken with every strobe, used by writes only
        pend_wdata_reg <= bus.wdata;
      end
    end
  end

  // ************************************************
  // Controller side apply
  // ************************************************
  // Write strobe to the register file, one cycle wide
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // No write out of reset
      o_reg_we <= 1'b0;
    end else if (i_ce) begin
      // Pulse only on the applying edge
      o_reg_we <= apply_wr;
    end
  end

  // Address seen by the register file. It stands until
  // the next applied access, so the file keeps presenting
  // the word that was last addressed.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Word zero addressed after reset
      o_reg_addr <= '0;
    end else if (i_ce) begin
      if (apply) begin
        // Reads move the address too
        o_reg_addr <= pend_addr_reg;
      end
    end
  end

  // Data seen by the register file; reads leave the last
  // written word in place
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Cleared data
      o_reg_wdata <= crab_pkg::DATA_RST;
    end else if (i_ce) begin
      if (apply_wr) begin
        // New word with its write strobe
        o_reg_wdata <= pend_wdata_reg;
      end
    end
  end

  // ************************************************
  // Read return
  // ************************************************
  // The register file answers for the address that stood
  // before this edge, so a read takes the word of the
  // previous access. The second read of a pair always finds
  // its own word in place.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Read data starts cleared
      bus.rdata <= crab_pkg::DATA_RST;
    end else if (i_ce) begin
      if (apply_rd) begin
        // Word of the previously addressed register
        bus.rdata <= i_reg_rdata;
      end
    end
  end

  // ************************************************
  // Limits
  // ************************************************
  // This end paces nothing itself: spacing and pairing
  // are the master's duty, and breaking them only loses or
  // scrambles data, never hangs this end.
endmodule

// >>> verilog/crab_master.sv
`timescale 1ns/1ps
// Master end: spaces writes, runs read-gap-read exclusively
module crab_master (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  crab_if.master bus,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [crab_pkg::ADDR_W-1:0] i_addr,
  input wire logic [crab_pkg::DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [crab_pkg::DATA_W-1:0] o_rdata
);
  // ************************************************
  // Sequencer
  // ************************************************
  crab_pkg::crab_state_t state_reg;
  logic [3:0] cnt_reg; // Gap countdown
  logic [crab_pkg::ADDR_W-1:0] addr_reg;
  logic [crab_pkg::DATA_W-1:0] wdata_reg;
  logic wr_reg;
  logic take;
  // Busy until the whole read sequence ends, so no other
  // access slips in between.
  assign o_ready = (state_reg == crab_pkg::CRAB_IDLE);
  assign take = o_ready & i_req;
  assign bus.req = take | (state_reg == crab_pkg::CRAB_FETCH);
  assign bus.wr = take ? i_wr : 1'b0;
  assign bus.addr = take ? i_addr : addr_reg;
  assign bus.wdata = take ? i_wdata : wdata_reg;
  // State walk
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= crab_pkg::CRAB_IDLE;
      cnt_reg <= crab_pkg::CNT_RST;
    end else if (i_ce) begin
      case (state_reg)
        crab_pkg::CRAB_IDLE: begin
          if (take) begin
            state_reg <= crab_pkg::CRAB_GAP;
            // Gap after the write or the launch read; gap rounded up.
            cnt_reg <= i_wr ? crab_pkg::WR_GAP
                            : crab_pkg::RD_GAP;
          end
        end
        crab_pkg::CRAB_GAP: begin
          // Ratio 1 gives a write no wait beyond one cycle; a read still waits READ_MIN_GAP.
          if (cnt_reg <= 4'h1) begin
            state_reg <= wr_reg ? crab_pkg::CRAB_IDLE
                                : crab_pkg::CRAB_FETCH;
          end
          cnt_reg <= cnt_reg - 4'h1;
        end
        crab_pkg::CRAB_FETCH: begin
          state_reg <= crab_pkg::CRAB_WAIT;
          cnt_reg <= crab_pkg::FETCH_WAIT;
        end
        crab_pkg::CRAB_WAIT: begin
          // Let the retrieving read settle before idle
          if (cnt_reg <= 4'h1) begin
            state_reg <= crab_pkg::CRAB_IDLE;
          end
          cnt_reg <= cnt_reg - 4'h1;
        end
        default: state_reg <= crab_pkg::CRAB_IDLE;
      endcase
    end
  end
  // Hold the request fields
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      addr_reg <= '0;
      wdata_reg <= crab_pkg::DATA_RST;
      wr_reg <= 1'b0;
    end else if (i_ce && take) begin
      addr_reg <= i_addr;
      wdata_reg <= i_wdata;
      wr_reg <= i_wr;
    end
  end
  // Second read's data is the valid result.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata <= crab_pkg::DATA_RST;
    end else if (i_ce) begin
      o_rvalid <= (state_reg == crab_pkg::CRAB_WAIT) && (cnt_reg == 4'h1);
      if ((state_reg == crab_pkg::CRAB_WAIT) && (cnt_reg == 4'h1)) begin
        o_rdata <= bus.rdata;
      end
    end
  end
endmodule

// >>> sim/crab_monitor.sv
`timescale 1ns/1ps
// ****
// Interface checks between the two ends
// ****
module crab_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [crab_pkg::ADDR_W-1:0] i_addr,
  input wire logic [crab_pkg::DATA_W-1:0] i_rdata
);
  logic rd_ph_reg; // High between the two read halves
  logic [crab_pkg::ADDR_W-1:0] la_addr_reg; // Launched address
  logic [3:0] since_reg; // Cycles since launch, saturating
  logic launch;
  logic fetch;
  assign launch = i_req && !i_wr && !rd_ph_reg;
  assign fetch = i_req && !i_wr && rd_ph_reg;
  // Pair up read halves; saturate so idle time never wraps
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rd_ph_reg <= 1'b0;
      la_addr_reg <= '0;
      since_reg <= 4'hF;
    end else begin
      if (i_req && !i_wr) rd_ph_reg <= !rd_ph_reg;
      if (launch) la_addr_reg <= i_addr;
      if (launch) since_reg <= 4'h0;
      else if (since_reg != 4'hF) since_reg <= since_reg + 4'h1;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence quiet2; !i_req [*2]; endsequence
  sequence fetch_s; i_req && !i_wr; endsequence
  wr_gap_a: assert property (i_req && i_wr |=> quiet2)
    else $error("write gap too short");
  read_space_a: assert property (launch |=> quiet2 ##1 fetch_s)
    else $error("read halves badly spaced");
  fetch_addr_a: assert property (fetch |-> i_addr == la_addr_reg)
    else $error("fetch address differs");
  read_excl_a: assert property (launch |=> !i_wr [*3])
    else $error("write inside read");
  fetch_quiet_a: assert property (fetch |=> quiet2)
    else $error("access too soon after fetch");
  strobe_pulse_a: assert property (i_req |=> !i_req)
    else $error("strobe longer than a cycle");
  fetch_origin_a: assert property (fetch |-> $past(launch, 3))
    else $error("fetch without launch");
  rdata_hold_a: assert property ($changed(i_rdata) |-> since_reg < 4'hC)
    else $error("read data moved without a read");
endmodule

// >>> sim/can_register_access_bridge_tb.sv
`timescale 1ns/1ps
module can_register_access_bridge_tb;
  // ****
  // Stimulus, two ends and checker
  // ****
  logic i_core_clk, i_rst_n, i_req, i_wr, i_can_tick;
  logic o_ready, o_rvalid, o_reg_we;
  logic [crab_pkg::ADDR_W-1:0] i_addr, o_reg_addr;
  logic [crab_pkg::DATA_W-1:0] i_wdata, o_rdata, o_reg_wdata, i_reg_rdata;
  logic [7:0] av [4] = '{8'h00, 8'h01, 8'h7E, 8'hFF}; // Edge addresses
  logic [7:0] last_a = 8'h00; // Address of the last landed access
  int fails, checked, cyc;
  crab_if bus_if ();
  crab_master u_crab_master (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_ce(1'b1), .bus(bus_if), .i_req(i_req), .i_wr(i_wr), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata));
  crab_ctrl u_crab_ctrl (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_ce(1'b1), .bus(bus_if), .o_reg_we(o_reg_we), .o_reg_addr(o_reg_addr),
    .o_reg_wdata(o_reg_wdata), .i_reg_rdata(i_reg_rdata),
    .i_can_tick(i_can_tick));
  crab_monitor u_crab_monitor (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_req(bus_if.req), .i_wr(bus_if.wr), .i_addr(bus_if.addr),
    .i_rdata(bus_if.rdata));
  // Register file echoes its address, so stale data shows at once
  assign i_reg_rdata = {24'h5A5A5A, o_reg_addr};
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  // Controller edges as a toggle, 8 MHz, off the core edges
  initial begin
    i_can_tick = 1'b0;
    #30;
    forever #125 i_can_tick = ~i_can_tick;
  end
  // Hang guard, far above the fewer than a hundred cycles needed
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc >= 3000) begin
      fails++;
      end_sim();
    end
  end
  task automatic cmp(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("FAIL %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One user access; waits for the landing write or the read data
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 50) begin
      @(posedge i_core_clk);
      #10 n++;
    end
    i_req = 1'b1;
    i_wr = w;
    i_addr = a;
    i_wdata = d;
    @(posedge i_core_clk);
    #10 i_req = 1'b0;
    cmp({31'h0, o_ready}, 32'h0);
    // Launch half lands before the fetch: previous word
    if (!w) begin
      repeat (3) @(posedge i_core_clk);
      #10 cmp(bus_if.rdata, {24'h5A5A5A, last_a});
    end
    n = 0;
    while ((w ? o_reg_we : o_rvalid) !== 1'b1 && n < 50) begin
      @(posedge i_core_clk);
      #10 n++;
    end
    if (w) cmp({o_reg_addr, o_reg_wdata[23:0]}, {a, d[23:0]});
    else cmp(o_rdata, {24'h5A5A5A, a});
    last_a = a;
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_req = 1'b0;
    i_wr = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    repeat (12) @(posedge i_core_clk);
    #10 i_rst_n = 1'b1;
    cmp({31'h0, o_ready}, 32'h1);
    for (int i = 0; i < 4; i++) acc(1'b1, av[i], {av[i], 24'hC3A50F});
    for (int i = 0; i < 4; i++) acc(1'b0, av[i], 32'h0);
    acc(1'b1, 8'h10, 32'hDEADBEEF);
    acc(1'b0, 8'h10, 32'h0);
    acc(1'b1, 8'h20, 32'h12345678);
    end_sim();
  end
endmodule
